// >>> hdl/cpuxf_params.svh
// Purpose: constants for the status word interrupt flag block
// Assumes: 32-bit status word, system register number 5
// Notes: included by the package and the design modules
// How it works
// - acknowledging a non-maskable interrupt sets status bit 7 so no interrupt nests on top of it.
// - bit 7 reads one while non-maskable handling runs and zero otherwise.
// - every taken software exception or maskable interrupt sets status bit 6, the exception flag; a non-maskable one does not.
// - a set exception flag never blocks interrupt acceptance.
// - status bit 5 set holds off maskable requests, clear lets them be acknowledged.
// - the word is system register 5, loaded and stored by the system register instructions.
// - a software exception or maskable interrupt copies the word into the save register first.
`ifndef CPUXF_PARAMS_SVH
`define CPUXF_PARAMS_SVH
`define CPUXF_WORD_W 32
`define CPUXF_SREG_W 5
`define CPUXF_SREG_STATUS 5'h05
`define CPUXF_SREG_SAVE 5'h01
`define CPUXF_BIT_NMI 7
`define CPUXF_BIT_EXC 6
`define CPUXF_BIT_ID 5
`define CPUXF_LOW_FLAGS_MSB 4
`define CPUXF_RESET_WORD 32'h0000_0020
`define CPUXF_SAVE_RESET 32'h0000_0000
`define CPUXF_WRITE_MASK 32'h0000_00ff
`endif

// >>> hdl/cpuxf_pkg.sv
// Purpose: types for the status word interrupt flag block
// Assumes: constants come from the params header
// Notes: event kinds that touch the flags
`default_nettype none
`include "cpuxf_params.svh"
package cpuxf_pkg;
  typedef logic [`CPUXF_WORD_W-1:0] cpuxf_word_t;
  typedef logic [`CPUXF_SREG_W-1:0] cpuxf_sreg_t;
  typedef enum logic [1:0] {
    CPUXF_EV_NONE,
    CPUXF_EV_NMI,
    CPUXF_EV_MASKABLE,
    CPUXF_EV_EXCEPTION
  } cpuxf_event_t;
endpackage
`default_nettype wire

// >>> hdl/cpuxf_accept.sv
// Purpose: decides which pending request may be acknowledged
// Assumes: inputs come from logic on the same clock
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "cpuxf_params.svh"
module cpuxf_accept
  import cpuxf_pkg::*;
(
  input wire cpuxf_pkg::cpuxf_word_t status_i,
  input wire logic nmi_req_i,
  input wire logic irq_req_i,
  output logic nmi_ack_o,
  output logic irq_ack_o
);
  import cpuxf_pkg::*;
  logic in_nmi;
  logic masked;
  always_comb begin
    in_nmi = status_i[`CPUXF_BIT_NMI];
    // exception flag deliberately not consulted
    masked = status_i[`CPUXF_BIT_ID] | in_nmi;
    nmi_ack_o = nmi_req_i & ~in_nmi;
    irq_ack_o = irq_req_i & ~masked & ~nmi_ack_o;
  end
endmodule
`default_nettype wire

// >>> hdl/cpuxf_status.sv
// Purpose: program status word interrupt and exception flags
// Assumes: one instruction-level event per cycle at most; load has lowest priority
// Assumes: requests and done strobes come from logic on the same clock, so no synchronisers
// Notes: low arithmetic flags are stored as written, their update lives elsewhere
// Notes: event sets beat done clears and loads in the same cycle
// Notes: status word bits above the low byte read zero and ignore loads; the save register takes all 32 bits
`timescale 1ns/1ps
`default_nettype none
`include "cpuxf_params.svh"
module cpuxf_status
  import cpuxf_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic NMI_REQ_I,
  input wire logic IRQ_REQ_I,
  input wire logic SW_EXC_I,
  input wire logic NMI_DONE_I,
  input wire logic EXC_DONE_I,
  input wire logic SREG_LOAD_I,
  input wire cpuxf_pkg::cpuxf_sreg_t SREG_NUM_I,
  input wire cpuxf_pkg::cpuxf_word_t SREG_WDATA_I,
  output cpuxf_pkg::cpuxf_word_t SREG_RDATA_O,
  output logic NMI_ACK_O,
  output logic IRQ_ACK_O,
  output cpuxf_pkg::cpuxf_word_t STATUS_O,
  output cpuxf_pkg::cpuxf_word_t IRQ_SAVE_O
);
  import cpuxf_pkg::*;

  // ----------------------------------------
  // internal signals
  // ----------------------------------------
  // registered state and next values
  // bits above the low byte are read-only zero
  localparam cpuxf_word_t write_mask = `CPUXF_WRITE_MASK;
  cpuxf_word_t program_status_word_r;
  cpuxf_word_t program_status_word_nxt;
  cpuxf_word_t irq_status_save_r;
  cpuxf_word_t irq_status_save_nxt;
  cpuxf_word_t rdata_r;
  cpuxf_word_t rdata_nxt;
  cpuxf_word_t status_loaded;
  cpuxf_word_t status_wr_mask;
  cpuxf_word_t status_set_mask;
  cpuxf_word_t status_clr_mask;

  // decoded strobes
  cpuxf_event_t ev;
  logic nmi_ack;
  logic irq_ack;
  logic sel_status;
  logic sel_save;
  logic load_status;
  logic load_save;
  logic clr_nmi;
  logic clr_exc;
  logic set_nmi;
  logic set_exc;
  logic set_id;
  logic take_save;

  // ----------------------------------------
  // acceptance
  // ----------------------------------------
  // bit 6 is not consulted by acceptance, so the exception flag alone never blocks a request
  cpuxf_accept u_accept (
    .status_i(program_status_word_r),
    .nmi_req_i(NMI_REQ_I),
    .irq_req_i(IRQ_REQ_I),
    .nmi_ack_o(nmi_ack),
    .irq_ack_o(irq_ack)
  );

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  // one event per cycle: an exception beside an ack is not taken
  always_comb begin
    if (nmi_ack) begin
      ev = CPUXF_EV_NMI;
    end else if (irq_ack) begin
      ev = CPUXF_EV_MASKABLE;
    end else if (SW_EXC_I) begin
      ev = CPUXF_EV_EXCEPTION;
    end else begin
      ev = CPUXF_EV_NONE;
    end
  end

  // maskable entry counts as exception processing too
  always_comb begin
    set_nmi = 1'b0;
    set_exc = 1'b0;
    set_id = 1'b0;
    take_save = 1'b0;
    unique case (ev)
      CPUXF_EV_NMI: begin
        set_nmi = 1'b1;
        set_id = 1'b1;
      end
      CPUXF_EV_MASKABLE, CPUXF_EV_EXCEPTION: begin
        take_save = 1'b1;
        set_exc = 1'b1;
        set_id = 1'b1;
      end
      CPUXF_EV_NONE: begin
      end
    endcase
  end

  // ----------------------------------------
  // system register access
  // ----------------------------------------
  // other numbers: loads ignored, reads give zero
  always_comb begin
    sel_status = (SREG_NUM_I == `CPUXF_SREG_STATUS);
    sel_save = (SREG_NUM_I == `CPUXF_SREG_SAVE);
    load_status = SREG_LOAD_I & sel_status;
    load_save = SREG_LOAD_I & sel_save;
    // done strobes only clear; a same-cycle event still sets
    clr_nmi = NMI_DONE_I;
    clr_exc = EXC_DONE_I;
  end

  // ----------------------------------------
  // per-bit set and clear masks
  // ----------------------------------------
  // only the three flag bits are touched by hardware
  for (genvar gi = 0; gi < `CPUXF_WORD_W; gi = gi + 1) begin : g_flag_bit
    // writable bits follow the low-byte mask
    assign status_wr_mask[gi] = write_mask[gi];
    if (gi == `CPUXF_BIT_NMI) begin : g_nmi
      assign status_set_mask[gi] = set_nmi;
      assign status_clr_mask[gi] = clr_nmi;
    end else if (gi == `CPUXF_BIT_EXC) begin : g_exc
      assign status_set_mask[gi] = set_exc;
      assign status_clr_mask[gi] = clr_exc;
    end else if (gi == `CPUXF_BIT_ID) begin : g_id
      assign status_set_mask[gi] = set_id;
      // only a software load clears the mask bit; reset sets it
      assign status_clr_mask[gi] = 1'b0;
    end else begin : g_plain
      assign status_set_mask[gi] = 1'b0;
      assign status_clr_mask[gi] = 1'b0;
    end
  end

  // ----------------------------------------
  // status word
  // ----------------------------------------
  // load, then done clears, then event sets: the set wins
  always_comb begin
    status_loaded = program_status_word_r;
    if (load_status) begin
      status_loaded = SREG_WDATA_I & status_wr_mask;
    end
    program_status_word_nxt = (status_loaded & ~status_clr_mask) | status_set_mask;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      program_status_word_r <= `CPUXF_RESET_WORD;
    end else begin
      program_status_word_r <= program_status_word_nxt;
    end
  end

  // ----------------------------------------
  // interrupt status save register
  // ----------------------------------------
  // single copy: nested handlers must store it before unmasking
  always_comb begin
    irq_status_save_nxt = irq_status_save_r;
    if (load_save) begin
      irq_status_save_nxt = SREG_WDATA_I;
    end
    if (take_save) begin
      irq_status_save_nxt = program_status_word_r;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      irq_status_save_r <= `CPUXF_SAVE_RESET;
    end else begin
      irq_status_save_r <= irq_status_save_nxt;
    end
  end

  // ----------------------------------------
  // store read data
  // ----------------------------------------
  // value before this cycle's update, shown one edge later
  always_comb begin
    rdata_nxt = `CPUXF_SAVE_RESET;
    if (sel_status) begin
      rdata_nxt = program_status_word_r;
    end else if (sel_save) begin
      rdata_nxt = irq_status_save_r;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      rdata_r <= `CPUXF_SAVE_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // acks stay combinational so a request is answered in its own cycle
  assign NMI_ACK_O = nmi_ack;
  assign IRQ_ACK_O = irq_ack;
  assign STATUS_O = program_status_word_r;
  assign IRQ_SAVE_O = irq_status_save_r;
  assign SREG_RDATA_O = rdata_r;
endmodule
`default_nettype wire

// >>> test/cpuxf_checker.sv
// Purpose: port-level checks of the status word flags
// Assumes: one clock, sync active-low reset
// Notes: bound from the bench file
`timescale 1ns/1ps
`default_nettype none
module cpuxf_checker (
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic NMI_REQ_I,
  input wire logic IRQ_REQ_I,
  input wire logic SW_EXC_I,
  input wire logic NMI_DONE_I,
  input wire logic EXC_DONE_I,
  input wire logic SREG_LOAD_I,
  input wire cpuxf_pkg::cpuxf_sreg_t SREG_NUM_I,
  input wire cpuxf_pkg::cpuxf_word_t SREG_WDATA_I,
  input wire cpuxf_pkg::cpuxf_word_t SREG_RDATA_O,
  input wire logic NMI_ACK_O,
  input wire logic IRQ_ACK_O,
  input wire cpuxf_pkg::cpuxf_word_t STATUS_O,
  input wire cpuxf_pkg::cpuxf_word_t IRQ_SAVE_O
);
  import cpuxf_pkg::*;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  // the load check runs only when no ack, exception or done strobe touches the flags
  wire logic quiet = !(NMI_ACK_O | IRQ_ACK_O | SW_EXC_I | NMI_DONE_I | EXC_DONE_I);
  sequence take_s;
    IRQ_ACK_O || (SW_EXC_I && !NMI_ACK_O);
  endsequence
  nmi_set_a: assert property (NMI_ACK_O |=> STATUS_O[7] && !NMI_ACK_O) else $error("nmi flag");
  nmi_clr_a: assert property (NMI_DONE_I && !NMI_ACK_O |=> !STATUS_O[7]) else $error("nmi clear");
  exc_set_a: assert property (SW_EXC_I && !NMI_ACK_O |=> STATUS_O[6]) else $error("exc flag");
  exc_pass_a: assert property (IRQ_REQ_I && !STATUS_O[5] && !STATUS_O[7] && !NMI_ACK_O |-> IRQ_ACK_O)
    else $error("irq blocked");
  mask_hold_a: assert property (STATUS_O[5] |-> !IRQ_ACK_O) else $error("irq not masked");
  load_word_a: assert property (SREG_LOAD_I && SREG_NUM_I == 5'h05 && quiet
    |=> STATUS_O == ($past(SREG_WDATA_I) & 32'h0000_00ff)) else $error("load");
  read_word_a: assert property (SREG_NUM_I == 5'h05 |=> SREG_RDATA_O == $past(STATUS_O)) else $error("read");
  save_word_a: assert property (take_s |=> IRQ_SAVE_O == $past(STATUS_O)) else $error("save");
  reset_word_a: assert property ($rose(RSTN_I) |-> STATUS_O == 32'h0000_0020 && IRQ_SAVE_O == 32'h0)
    else $error("reset");
endmodule
`default_nettype wire

// >>> test/cpuxf_status_tb.sv
// Purpose: self-checking bench for the status flags
// Assumes: inputs change 1 ns after the rising edge
// Notes: random phase leans on the checker
`timescale 1ns/1ps
`default_nettype none
module cpuxf_status_tb;
  import cpuxf_pkg::*;
  logic clk = 0, rstn = 0, nmi = 0, irq = 0, exc = 0, nd = 0, ed = 0, ld = 0, nack, iack;
  cpuxf_sreg_t num = 5'h05;
  cpuxf_word_t wd = '0, rd, st, sv, d;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  cpuxf_status dut (.CLOCK_I(clk), .RSTN_I(rstn), .NMI_REQ_I(nmi), .IRQ_REQ_I(irq), .SW_EXC_I(exc),
    .NMI_DONE_I(nd), .EXC_DONE_I(ed), .SREG_LOAD_I(ld), .SREG_NUM_I(num), .SREG_WDATA_I(wd),
    .SREG_RDATA_O(rd), .NMI_ACK_O(nack), .IRQ_ACK_O(iack), .STATUS_O(st), .IRQ_SAVE_O(sv));
  function automatic cpuxf_word_t masked(cpuxf_word_t v);
    return v & 32'h0000_00ff;
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(cpuxf_word_t g, cpuxf_word_t e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic load(cpuxf_word_t v);
    ld = 1;
    wd = v;
    step();
    ld = 0;
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // cycle ceiling well above the ~1500 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(74032));
    repeat (4) step();
    chk(st, 32'h0000_0020);
    chk(sv, 32'h0);
    rstn = 1;
    irq = 1;
    step();
    chk(iack, 1'b0);
    d = ($urandom & 32'hffff_ff1f) | 32'h40;
    load(d);
    chk(st, masked(d));
    chk(iack, 1'b1);
    step();
    irq = 0;
    chk(rd, masked(d));
    chk(sv, masked(d));
    chk(st[6:5], 2'b11);
    $display("load and irq test done");
    nmi = 1;
    #1;
    chk(nack, 1'b1);
    step();
    chk(st[7], 1'b1);
    chk(nack, 1'b0);
    nmi = 0;
    nd = 1;
    step();
    nd = 0;
    chk(st[7], 1'b0);
    load(32'h0);
    exc = 1;
    step();
    exc = 0;
    chk(st[6], 1'b1);
    chk(sv, 32'h0);
    $display("nmi and exception test done");
    num = 5'h01;
    load(d);
    chk(sv, d);
    step();
    chk(rd, d);
    num = 5'h02;
    step();
    chk(rd, 32'h0);
    num = 5'h05;
    $display("save register test done");
    repeat (1500) begin
      step();
      chk(nack, nmi & !st[7]);
      chk(iack, irq & !st[5] & !st[7] & !nmi);
      {nmi, irq, exc, nd, ed, ld} = 6'($urandom);
      num = ($urandom & 1) ? 5'h05 : 5'($urandom);
      wd = $urandom;
      rstn = ($urandom_range(0, 199) != 0);
    end
    $display("random test done");
    print_verdict();
  end
endmodule
bind cpuxf_status cpuxf_checker chk_i (.CLOCK_I, .RSTN_I, .NMI_REQ_I, .IRQ_REQ_I, .SW_EXC_I, .NMI_DONE_I,
  .EXC_DONE_I, .SREG_LOAD_I, .SREG_NUM_I, .SREG_WDATA_I, .SREG_RDATA_O, .NMI_ACK_O, .IRQ_ACK_O,
  .STATUS_O, .IRQ_SAVE_O);
`default_nettype wire
